// *** verif/ufrc_fire_receive_assertions.sv ***
// port assertions for the fire and receive control block
// assumes a bind onto ufrc_fire_receive, one clock domain
`timescale 1ns/1ps
module ufrc_fire_receive_assertions #(
  parameter int unsigned TMO3_CYC = 163840
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sequencer
  input wire logic cycleTrig,
  input wire logic shotDone,
  input wire logic zeroCalReq,
  // transducer side
  input wire logic fireUp,
  input wire logic fireDown,
  input wire logic shotDirDown,
  input wire logic rxEnable,
  input wire logic rxGated,
  input wire logic [1:0] pathSel,
  input wire logic gasModeEn
);
  logic [31:0] rxCnt_reg;
  // receive cannot outlast the longest timeout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxCnt_reg <= 32'h0;
    end else begin
      rxCnt_reg <= rxEnable ? rxCnt_reg + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rx_bound_a: assert property (rxCnt_reg <= TMO3_CYC)
    else $error("receive state outlasts timeout");
  mask_gate_a: assert property (!rxEnable && !$past(rxEnable) |-> !rxGated)
    else $error("receive path open outside receiving");
  fire_masked_a: assert property (fireUp || fireDown |-> !rxEnable)
    else $error("receiving while firing");
  dir_up_a: assert property (fireUp |-> !shotDirDown && !fireDown)
    else $error("up burst in down shot");
  dir_down_a: assert property (fireDown |-> shotDirDown && !fireUp)
    else $error("down burst in up shot");
  gas_reset_a: assert property ($rose(rst_b) |-> gasModeEn)
    else $error("gas mode not set after reset");
  path_none_a: assert property (pathSel == 2'b00 |-> !fireUp && !fireDown)
    else $error("firing with no path");
  cal_trig_a: assert property (zeroCalReq |-> $past(cycleTrig))
    else $error("calibration without trigger");
  done_pulse_a: assert property (shotDone |=> !shotDone && !rxEnable)
    else $error("shot end not a single pulse");
endmodule
bind ufrc_fire_receive ufrc_fire_receive_assertions #(.TMO3_CYC(TMO3_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .cycleTrig(cycleTrig), .shotDone(shotDone),
  .zeroCalReq(zeroCalReq), .fireUp(fireUp), .fireDown(fireDown),
  .shotDirDown(shotDirDown), .rxEnable(rxEnable), .rxGated(rxGated),
  .pathSel(pathSel), .gasModeEn(gasModeEn));

// *** verif/ufrc_fire_receive_tb_top.sv ***
// register, shot, timeout and calibration tests of the block
// assumes the transducer model and the bound checker
`timescale 1ns/1ps
module ufrc_fire_receive_tb_top import ufrc_pkg::*;;
  localparam int TMO [4] = '{600, 700, 800, 900};
  logic clk, rst_b, ce, psel, penable, pwrite, startReq, cycleTrig, rxPin, echoOn;
  logic pready, pslverr, shotDone, zeroCalReq, irq, fireUp, fireDown, shotDirDown;
  logic rxEnable, rxGated, extAmpEn, gasModeEn, firstLevelNeg, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] pathSel;
  logic [4:0] pathEnables;
  logic [7:0] echoDly;
  int num_errors, tests_run, calCnt, nUp, nDn, tRx, tEnd, tP1, tP2, r2, ofs;
  ufrc_fire_receive #(.TMO0_CYC(600), .TMO1_CYC(700), .TMO2_CYC(800), .TMO3_CYC(900),
    .BASE_PERIOD_CYC(80)) u_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startReq(startReq), .cycleTrig(cycleTrig), .shotDone(shotDone),
    .zeroCalReq(zeroCalReq), .irq(irq), .rxPin(rxPin), .fireUp(fireUp),
    .fireDown(fireDown), .shotDirDown(shotDirDown), .rxEnable(rxEnable),
    .rxGated(rxGated), .pathSel(pathSel), .pathEnables(pathEnables),
    .extAmpEn(extAmpEn), .gasModeEn(gasModeEn), .firstLevelNeg(firstLevelNeg));
  ufrc_xdcr_model u_xdcr (.clk(clk), .fireUp(fireUp), .fireDown(fireDown),
    .rxEnable(rxEnable), .echoOn(echoOn), .echoDly(echoDly), .rxPin(rxPin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (zeroCalReq === 1'b1) calCnt++;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // called just after a rising edge, returns one edge after release
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) num_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp(q, exp);
  endtask
  function automatic logic [31:0] frcV(input logic [2:0] zc, input logic [6:0] dv);
    return (32'h1 << FRC_PSEL_LSB) | (32'(zc) << FRC_ZCC_LSB) | (32'h3 << FRC_FPN_LSB) | 32'(dv);
  endfunction
  function automatic logic [31:0] prcV(input logic [1:0] to, input logic [7:0] win,
    input logic [1:0] dir, input logic [2:0] pa);
    return (32'(to) << PRC_TO_LSB) | (32'(win) << PRC_WIN_LSB) | (32'(dir) << PRC_DIR_LSB) |
      32'(pa);
  endfunction
  // launch and follow shots, tP2 ends as the last gap between pulse rises
  task automatic shot(input int shots);
    int n, done;
    logic pu, pd;
    n = 0;
    done = 0;
    pu = 1'b0;
    pd = 1'b0;
    {nUp, nDn, tRx, tP1, tP2} = '0;
    startReq <= 1'b1;
    @(posedge clk);
    startReq <= 1'b0;
    while (done < shots && n < 3000) begin
      @(posedge clk);
      n++;
      if (fireUp === 1'b1 && !pu) begin
        nUp++;
        tP2 = n - tP1;
        tP1 = n;
      end
      if (fireDown === 1'b1 && !pd) begin
        nDn++;
        tP2 = n - tP1;
        tP1 = n;
      end
      pu = fireUp;
      pd = fireDown;
      if (rxEnable === 1'b1 && tRx == 0) tRx = n;
      if (shotDone === 1'b1) done++;
    end
    tEnd = n;
    if (n == 3000) num_errors++;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    logic [1:0] dirs [5];
    logic [6:0] divs [5];
    logic [2:0] zcs [3];
    int pers [5], trg [3], cal [3];
    dirs = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h1};
    divs = '{7'h00, 7'h03, 7'h7F, 7'h03, 7'h03};
    pers = '{2, 4, 128, 4, 4};
    zcs = '{3'h0, 3'h2, 3'h4};
    trg = '{3, 4, 10};
    cal = '{0, 2, 1};
    {psel, penable, pwrite, startReq, cycleTrig} = '0;
    {paddr, pwdata} = '0;
    {num_errors, tests_run, calCnt} = '0;
    ce = 1'b1;
    echoOn = 1'b1;
    echoDly = 8'h04;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(IDX_PRC, 32'h0);
    rd(IDX_FRC, 32'h0400_0000);
    cmp(32'({gasModeEn, extAmpEn}), 32'h2);
    apb(1'b1, IDX_FRC, 32'hFFFF_FFFF);
    rd(IDX_FRC, 32'h07FF_FFFF);
    cmp(32'({firstLevelNeg, extAmpEn, pathSel, pathEnables}), 32'h1FF);
    apb(1'b1, IDX_PRC, 32'hFFFF_FFFF);
    rd(IDX_PRC, 32'h0003_FF37);
    apb(1'b0, 10'h3FF, 32'h0);
    cmp(32'(err), 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, IDX_FRC, frcV(3'h0, divs[i]));
      // software keeps the pause field off the forbidden code
      apb(1'b1, IDX_PRC, prcV(2'h0, (i == 4) ? 8'h04 : 8'h02, dirs[i], 3'h0));
      shot(1);
      cmp(32'(nUp + nDn), 32'h3);
      cmp(32'(nDn), (i == 1 || i == 4) ? 32'h3 : 32'h0);
      cmp(32'(tP2), 32'(pers[i]));
      if (i == 0) cmp(32'(tRx >= 62 && tRx <= 67), 32'h1);
      if (i == 3) r2 = tRx;
    end
    cmp(32'(tRx - r2), 32'd80);
    echoDly = 8'd40;
    apb(1'b1, IDX_PRC, prcV(2'h0, 8'h02, 2'h0, 3'h2));
    shot(2);
    cmp(32'({nUp[7:0], nDn[7:0]}), 32'h0303);
    // no path selected: the pair still runs, but no burst may leave
    apb(1'b1, IDX_FRC, frcV(3'h0, 7'h03) & ~(32'h3 << FRC_PSEL_LSB));
    shot(2);
    cmp(32'(nUp + nDn), 32'h0);
    apb(1'b1, IDX_MASK, 32'(1) << EV_TMO);
    cmp(32'(irq), 32'h0);
    echoOn = 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, IDX_PRC, prcV(2'(i), 8'h02, 2'h0, 3'h0));
      shot(1);
      if (i == 0) ofs = tEnd - TMO[0];
      cmp(32'(tEnd - TMO[i]), 32'(ofs));
      cmp(32'(ofs >= 0 && ofs <= 4 && irq === 1'b1), 32'h1);
      apb(1'b0, IDX_STAT, 32'h0);
      cmp(q & 32'h2, 32'h2);
      apb(1'b1, IDX_STAT, 32'h7);
      @(posedge clk);
      cmp(32'(irq), 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_FRC, frcV(zcs[i], 7'h03));
      calCnt = 0;
      repeat (trg[i]) begin
        cycleTrig <= 1'b1;
        @(posedge clk);
        cycleTrig <= 1'b0;
        repeat (2) @(posedge clk);
      end
      cmp(32'(calCnt), 32'(cal[i]));
    end
    close_out();
  end
endmodule

// *** verif/ufrc_xdcr_model.sv ***
// transducer pair seen through the fire buffers and comparator
// assumes the device clock; echo delay set by the bench
`timescale 1ns/1ps
module ufrc_xdcr_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic fireUp,
  input wire logic fireDown,
  input wire logic rxEnable,
  // scenario
  input wire logic echoOn,
  input wire logic [7:0] echoDly,
  // comparator
  output logic rxPin
);
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= (rxEnable === 1'b1) ? cnt + 1 : 0;
  end
  // burst crosstalk hits the comparator, the device must mask it
  assign rxPin = fireUp || fireDown ||
    (echoOn && cnt >= echoDly && cnt < echoDly + 6);
endmodule

// *** verilog/ufrc_fire_div.sv ***
// fire clock divider: period of div+1 cycles, code 0 behaves as 1
// phase is high for the first half of each period, tick marks its last cycle
`timescale 1ns/1ps
module ufrc_fire_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic [6:0] div,
  // divided clock
  output logic phase,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic phase;
    logic tick;
  } ufrc_div_s;
  ufrc_div_s r_reg, r_next;
  logic [6:0] last;
  logic [7:0] half;

  always_comb begin
    last = (div == 7'h00) ? 7'h01 : div;
    half = ({1'b0, last} + 8'h02) >> 1;
    r_next = r_reg;
    r_next.tick = 1'b0;
    r_next.phase = 1'b0;
    if (!run) begin
      r_next.cnt = 7'h00;
    end else begin
      r_next.phase = ({1'b0, r_reg.cnt} < half);
      if (r_reg.cnt == last) begin
        r_next.cnt = 7'h00;
        r_next.tick = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign phase = r_reg.phase;
  assign tick = r_reg.tick;
endmodule

// *** verilog/ufrc_fire_receive.sv ***
// ultrasonic fire and receive control with its APB register file
// assumes startReq and cycleTrig come from the sequencer on clk; rxPin is asynchronous
// Overview of operation
// - a shot ends on timeout after 128, 256, 1024 or 4096 us for select codes 00 to 11.
// - the receive path is suppressed from the first fire pulse until the switch to receiving.
// - the mask window lasts the eight-bit value times 1 us minus 0.4 us.
// - direction code 00 starts up, 01 starts down, 1x alternates the start every measurement.
// - pause code 000 gives one shot, 010 to 111 give 0.25 to 2.5 base periods, 001 is illegal.
// - the gas application enable resets to one.
// - bit 20 of the fire and receive control register enables the external amplifier.
// - the path code selects no path, path one, path two or both.
// - zero-cross calibration runs never or every 1, 2, 5, 10, 20, 50 or 100 cycle triggers.
// - the polarity bit puts the first-hit level above (0) or below (1) the zero-cross level.
// - the fire pulse count is a seven-bit field in bits 13 to 7, resetting to zero.
// - the fire clock is the fast clock divided by divider plus one, zero dividing by two.
`timescale 1ns/1ps
module ufrc_fire_receive import ufrc_pkg::*; #(
  parameter int unsigned TMO0_CYC = TMO0_US * US_NS / CLK_NS,
  parameter int unsigned TMO1_CYC = TMO1_US * US_NS / CLK_NS,
  parameter int unsigned TMO2_CYC = TMO2_US * US_NS / CLK_NS,
  parameter int unsigned TMO3_CYC = TMO3_US * US_NS / CLK_NS,
  parameter int unsigned BASE_PERIOD_CYC = BASE_PERIOD_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer
  input wire logic startReq,
  input wire logic cycleTrig,
  output logic shotDone,
  output logic zeroCalReq,
  output logic irq,
  // transducer interface
  input wire logic rxPin,
  output logic fireUp,
  output logic fireDown,
  output logic shotDirDown,
  output logic rxEnable,
  output logic rxGated,
  output logic [1:0] pathSel,
  output logic [4:0] pathEnables,
  output logic extAmpEn,
  output logic gasModeEn,
  output logic firstLevelNeg
);
  localparam int unsigned QTR_CYC = BASE_PERIOD_CYC / 4;

  typedef struct packed {
    logic [31:0] prc;
    logic [31:0] frc;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    ufrc_state_e st;
    logic curDown;
    logic toggleDown;
    logic second;
    logic [6:0] pulses;
    logic rxEn;
    logic [2:0] rxSync;
    logic rxLvl;
    logic rxPrev;
    logic rxGated;
    logic fireUp;
    logic fireDown;
    logic [6:0] calCnt;
    logic calReq;
    logic shotDone;
  } ufrc_core_s;
  ufrc_core_s r_reg, r_next;

  ufrc_tmr_if tmoTmr ();
  ufrc_tmr_if maskTmr ();
  ufrc_tmr_if pauseTmr ();

  logic divPhase;
  logic divTick;
  logic fireRun;
  logic launch;
  logic launchDown;
  logic [1:0] toSel;
  logic [7:0] winVal;
  logic [1:0] dirMode;
  logic [3:0] pauseQ;
  logic [6:0] fpCount;
  logic [6:0] fpDiv;
  logic [6:0] calRate;
  logic lastPulse;

  // field views
  assign toSel = r_reg.prc[PRC_TO_LSB +: 2];
  assign winVal = r_reg.prc[PRC_WIN_LSB +: 8];
  assign dirMode = r_reg.prc[PRC_DIR_LSB +: 2];
  assign pauseQ = ufrc_pause_q(r_reg.prc[PRC_PAUSE_LSB +: 3]);
  assign fpCount = r_reg.frc[FRC_FPN_LSB +: 7];
  assign fpDiv = r_reg.frc[FRC_DIV_LSB +: 7];
  assign calRate = ufrc_zero_level_cal_rate(r_reg.frc[FRC_ZCC_LSB +: 3]);
  assign lastPulse = divTick && (r_reg.pulses + 7'h01 == fpCount);

  // divider stops on the last tick itself, otherwise one extra high cycle leaks out
  assign fireRun = (r_reg.st == ST_FIRE) && !lastPulse;

  // a shot starts from idle or when the pause of a pair runs out
  assign launch = ((r_reg.st == ST_IDLE) && startReq) ||
                  ((r_reg.st == ST_PAUSE) && pauseTmr.done);

  always_comb begin
    if (r_reg.st == ST_PAUSE) begin
      launchDown = !r_reg.curDown;
    end else begin
      case (dirMode)
        2'b00: launchDown = 1'b0;
        2'b01: launchDown = 1'b1;
        default: launchDown = r_reg.toggleDown;
      endcase
    end
  end

  // timeout interval per select code
  assign tmoTmr.load = launch;
  always_comb begin
    case (toSel)
      2'b00: tmoTmr.val = TMR_W'(TMO0_CYC);
      2'b01: tmoTmr.val = TMR_W'(TMO1_CYC);
      2'b10: tmoTmr.val = TMR_W'(TMO2_CYC);
      default: tmoTmr.val = TMR_W'(TMO3_CYC);
    endcase
  end

  // window shorter than one cycle is held at one
  assign maskTmr.load = launch;
  assign maskTmr.val = (winVal == 8'h00) ? TMR_W'(1) :
                       TMR_W'(32'(winVal) * MASK_LSB_CYC - MASK_OFS_CYC);

  assign pauseTmr.val = TMR_W'(32'(pauseQ) * QTR_CYC);

  ufrc_timer u_tmo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .t(tmoTmr.tmr)
  );

  ufrc_timer u_mask (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .t(maskTmr.tmr)
  );

  ufrc_timer u_pause (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .t(pauseTmr.tmr)
  );

  ufrc_fire_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .run(fireRun),
    .div(fpDiv),
    .phase(divPhase),
    .tick(divTick)
  );

  logic apbAcc;
  logic apbWr;
  logic [9:0] idx;
  logic mapped;
  logic [31:0] rdVal;
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;
  logic shotEnd;
  logic shotTmo;
  logic pairNext;

  always_comb begin
    r_next = r_reg;
    idx = paddr[11:2];
    apbAcc = psel && penable;
    evSet = '0;
    evClr = '0;
    shotEnd = 1'b0;
    shotTmo = 1'b0;
    pairNext = 1'b0;
    pauseTmr.load = 1'b0;

    // register decode
    mapped = 1'b1;
    rdVal = 32'h0000_0000;
    case (idx)
      IDX_PRC: rdVal = r_reg.prc;
      IDX_FRC: rdVal = r_reg.frc;
      IDX_STAT: rdVal = 32'(r_reg.stat);
      IDX_MASK: rdVal = 32'(r_reg.mask);
      IDX_STATE: rdVal = {25'h0, r_reg.second, r_reg.rxEn, r_reg.curDown, 1'b0, r_reg.st};
      default: mapped = 1'b0;
    endcase

    // one wait state: answer in the second access cycle, commit on that edge
    apbWr = apbAcc && r_reg.pready && pwrite && !r_reg.pslverr;
    if (apbAcc && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.pslverr = !mapped;
      r_next.prdata = (pwrite || !mapped) ? 32'h0000_0000 : rdVal;
    end else begin
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
    end
    if (apbWr) begin
      case (idx)
        IDX_PRC: r_next.prc = pwdata & PRC_WMASK;
        IDX_FRC: r_next.frc = pwdata & FRC_WMASK;
        IDX_STAT: evClr = pwdata[EV_W-1:0];
        IDX_MASK: r_next.mask = pwdata[EV_W-1:0];
        default: r_next.mask = r_reg.mask;
      endcase
    end

    // receive pin: three flops, level moves once the last two agree
    r_next.rxSync = {r_reg.rxSync[1:0], rxPin};
    if (r_reg.rxSync[1] == r_reg.rxSync[2]) begin
      r_next.rxLvl = r_reg.rxSync[2];
    end
    r_next.rxPrev = r_reg.rxLvl;
    r_next.rxGated = r_reg.rxLvl && (r_reg.st == ST_RECV);

    // shot sequence
    r_next.shotDone = 1'b0;
    case (r_reg.st)
      ST_IDLE: begin
        r_next.second = 1'b0;
      end
      ST_FIRE: begin
        if (divTick) begin
          r_next.pulses = r_reg.pulses + 7'h01;
        end
        if (lastPulse) begin
          r_next.st = ST_MASK;
        end
        if (tmoTmr.done) begin
          shotEnd = 1'b1;
          shotTmo = 1'b1;
        end
      end
      ST_MASK: begin
        if (tmoTmr.done) begin
          shotEnd = 1'b1;
          shotTmo = 1'b1;
        end else if (!maskTmr.busy) begin
          r_next.st = ST_RECV;
          r_next.rxEn = 1'b1;
        end
      end
      ST_RECV: begin
        if (tmoTmr.done) begin
          shotEnd = 1'b1;
          shotTmo = 1'b1;
        end else if (r_reg.rxLvl && !r_reg.rxPrev) begin
          shotEnd = 1'b1;
        end
      end
      ST_PAUSE: begin
        r_next.st = ST_PAUSE;
      end
      default: r_next.st = ST_IDLE;
    endcase

    if (shotEnd) begin
      r_next.rxEn = 1'b0;
      r_next.shotDone = 1'b1;
      evSet[EV_DONE] = 1'b1;
      evSet[EV_TMO] = shotTmo;
      pairNext = !r_reg.second && (pauseQ != 4'h0);
      pauseTmr.load = pairNext;
      r_next.st = pairNext ? ST_PAUSE : ST_IDLE;
      r_next.second = pairNext;
    end

    if (launch) begin
      r_next.curDown = launchDown;
      r_next.pulses = 7'h00;
      r_next.rxEn = 1'b0;
      r_next.st = (fpCount == 7'h00) ? ST_MASK : ST_FIRE;
      if ((r_reg.st == ST_IDLE) && dirMode[1]) begin
        r_next.toggleDown = !r_reg.toggleDown;
      end
    end

    // fire pulses only leave through a selected path
    // next path code, so a deselect mid-burst cuts the burst on the same edge
    r_next.fireUp = divPhase && !r_reg.curDown && (r_next.frc[FRC_PSEL_LSB +: 2] != 2'b00);
    r_next.fireDown = divPhase && r_reg.curDown && (r_next.frc[FRC_PSEL_LSB +: 2] != 2'b00);

    // zero-cross calibration divider on cycle triggers
    r_next.calReq = 1'b0;
    if (calRate == 7'h00) begin
      r_next.calCnt = 7'h00;
    end else if (cycleTrig) begin
      if (r_reg.calCnt + 7'h01 >= calRate) begin
        r_next.calCnt = 7'h00;
        r_next.calReq = 1'b1;
        evSet[EV_CAL] = 1'b1;
      end else begin
        r_next.calCnt = r_reg.calCnt + 7'h01;
      end
    end

    // sticky events, a new event beats a clear in the same cycle
    r_next.stat = (r_reg.stat & ~evClr) | evSet;
    r_next.irq = |(r_next.stat & r_next.mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.prc <= PRC_RST;
      r_reg.frc <= FRC_RST;
      r_reg.st <= ST_IDLE;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign shotDone = r_reg.shotDone;
  assign zeroCalReq = r_reg.calReq;
  assign irq = r_reg.irq;
  assign fireUp = r_reg.fireUp;
  assign fireDown = r_reg.fireDown;
  assign shotDirDown = r_reg.curDown;
  assign rxEnable = r_reg.rxEn;
  assign rxGated = r_reg.rxGated;
  assign pathSel = r_reg.frc[FRC_PSEL_LSB +: 2];
  assign pathEnables = r_reg.frc[FRC_PEN_LSB +: 5];
  assign extAmpEn = r_reg.frc[FRC_AMP_BIT];
  assign gasModeEn = r_reg.frc[FRC_GM_BIT];
  assign firstLevelNeg = r_reg.frc[FRC_POL_BIT];
endmodule

// *** verilog/ufrc_pkg.sv ***
// constants, field layout and state codes of the fire and receive control block
// assumes a 40 MHz core clock that also serves as the high-speed fire clock
package ufrc_pkg;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned US_NS = 1000;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_PRC = 10'h0C8;
  localparam logic [9:0] IDX_FRC = 10'h0C9;
  localparam logic [9:0] IDX_STAT = 10'h0D0;
  localparam logic [9:0] IDX_MASK = 10'h0D1;
  localparam logic [9:0] IDX_STATE = 10'h0D2;
  // processing config fields
  localparam int PRC_TO_LSB = 16;
  localparam int PRC_WIN_LSB = 8;
  localparam int PRC_DIR_LSB = 4;
  localparam int PRC_PAUSE_LSB = 0;
  localparam logic [31:0] PRC_WMASK = 32'h0003_FF37;
  localparam logic [31:0] PRC_RST = 32'h0000_0000;
  // fire and receive control fields
  localparam int FRC_GM_BIT = 26;
  localparam int FRC_PEN_LSB = 21;
  localparam int FRC_AMP_BIT = 20;
  localparam int FRC_PSEL_LSB = 18;
  localparam int FRC_ZCC_LSB = 15;
  localparam int FRC_POL_BIT = 14;
  localparam int FRC_FPN_LSB = 7;
  localparam int FRC_DIV_LSB = 0;
  localparam logic [31:0] FRC_WMASK = 32'h07FF_FFFF;
  localparam logic [31:0] FRC_RST = 32'h0400_0000;
  // event bits of status and mask
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_TMO = 1;
  localparam int EV_CAL = 2;
  // timing
  localparam int unsigned TMO0_US = 128;
  localparam int unsigned TMO1_US = 256;
  localparam int unsigned TMO2_US = 1024;
  localparam int unsigned TMO3_US = 4096;
  localparam int unsigned MASK_LSB_NS = 1000;
  localparam int unsigned MASK_OFS_NS = 400;
  localparam int unsigned MASK_LSB_CYC = MASK_LSB_NS / CLK_NS;
  localparam int unsigned MASK_OFS_CYC = MASK_OFS_NS / CLK_NS;
  localparam int unsigned BASE_PERIOD_DEF = 40000;
  localparam int TMR_W = 24;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIRE = 3'b001,
    ST_MASK = 3'b010,
    ST_RECV = 3'b011,
    ST_PAUSE = 3'b100
  } ufrc_state_e;

  // pause in quarters of the base period
  function automatic logic [3:0] ufrc_pause_q(input logic [2:0] code);
    case (code)
      3'h2: return 4'h1;
      3'h3: return 4'h2;
      3'h4: return 4'h4;
      3'h5: return 4'h6;
      3'h6: return 4'h8;
      3'h7: return 4'hA;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [6:0] ufrc_zero_level_cal_rate(input logic [2:0] code);
    case (code)
      3'h1: return 7'h01;
      3'h2: return 7'h02;
      3'h3: return 7'h05;
      3'h4: return 7'h0A;
      3'h5: return 7'h14;
      3'h6: return 7'h32;
      3'h7: return 7'h64;
      default: return 7'h00;
    endcase
  endfunction
endpackage

// *** verilog/ufrc_timer.sv ***
// one-shot interval timer, restarted by every load
// assumes load values of at least one cycle; zero is taken as one
`timescale 1ns/1ps
module ufrc_timer import ufrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // control side
  ufrc_tmr_if.tmr t
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic busy;
    logic done;
  } ufrc_tmr_s;
  ufrc_tmr_s r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (t.load) begin
      r_next.cnt = (t.val == '0) ? TMR_W'(1) : t.val;
      r_next.busy = 1'b1;
    end else if (r_reg.busy) begin
      if (r_reg.cnt == TMR_W'(1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign t.busy = r_reg.busy;
  assign t.done = r_reg.done;
endmodule

// *** verilog/ufrc_tmr_if.sv ***
// load and expiry signals between the control core and one interval timer
// assumes both ends share clk
`timescale 1ns/1ps
interface ufrc_tmr_if import ufrc_pkg::*; ();
  logic load;
  logic [TMR_W-1:0] val;
  logic busy;
  logic done;
  modport ctl (output load, output val, input busy, input done);
  modport tmr (input load, input val, output busy, output done);
endinterface
